/* tb/srs_sequencer_chk.sv */
module srs_chk #(
    parameter int OC_FILTER_CYC = 8,
    parameter int FAULT_TIMER_CYC = 10
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic rail_above_lockout,
    input wire logic onoff_above_threshold,
    input wire logic over_temp,
    input wire logic overcurrent_trip,
    input wire logic sequence_select,
    input wire logic [3:0] regulator_delay_pin_trip,
    input wire logic [5:0] undervoltage,
    input wire logic supervisor_monitor_input,
    input wire logic internal_supply_rail_on,
    input wire logic gate_drive_enable,
    input wire logic converter_enable,
    input wire logic [5:0] regulator_enable,
    input wire logic [5:0] ramp_done,
    input wire logic [35:0] ramp_level,
    input wire logic sequence_enable,
    input wire logic delay_charge_on,
    input wire logic delay_discharge_on,
    input wire logic supervisor_reset_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_uv_cyc;
        converter_enable && ramp_done[1] && undervoltage[1];
    endsequence
    sequence s_uv_held;
        s_uv_cyc[*5] ##1 s_uv_cyc[*5];
    endsequence
    a_lockout_gates_off: assert property (!rail_above_lockout |-> !gate_drive_enable)
        else $error("gate drive on under lockout");
    a_enable_needs_all: assert property (converter_enable |->
        rail_above_lockout && onoff_above_threshold && internal_supply_rail_on)
        else $error("enabled without all conditions");
    a_block_same_cycle: assert property (sequence_enable == converter_enable)
        else $error("sequence block not with converter");
    a_charge_on_select: assert property (delay_charge_on == (sequence_select && sequence_enable))
        else $error("delay charge mismatch");
    a_discharge_otherwise: assert property (delay_discharge_on != delay_charge_on)
        else $error("delay discharge mismatch");
    a_logic_after_ramp: assert property ($rose(regulator_enable[1]) |-> ramp_done[0])
        else $error("logic rail before converter ramp");
    a_trip_enables_reg: assert property (delay_charge_on && regulator_delay_pin_trip[1]
        ##1 sequence_enable |-> regulator_enable[3])
        else $error("trip did not enable regulator");
    a_pos_ramp_top: assert property (ramp_done[0] |-> ramp_level[5:0] == 6'h20)
        else $error("positive ramp end wrong");
    a_neg_ramp_end: assert property (ramp_done[5] |-> ramp_level[35:30] == 6'h00)
        else $error("negative ramp end wrong");
    a_thermal_kills_all: assert property (over_temp |=> !internal_supply_rail_on)
        else $error("rail on after over temperature");
    a_supervisor_low: assert property ((!supervisor_monitor_input || !onoff_above_threshold)
        |=> supervisor_reset_oe)
        else $error("supervisor released while bad");
    a_uv_timer_fault: assert property (s_uv_held |-> ##[1:2] !converter_enable)
        else $error("persistent undervoltage ignored");
    a_oc_filter_trip: assert property (overcurrent_trip[*8] |-> ##[1:2] !converter_enable)
        else $error("held overcurrent ignored");
endmodule : srs_chk

bind srs_sequencer srs_chk #(.OC_FILTER_CYC(OC_FILTER_CYC), .FAULT_TIMER_CYC(FAULT_TIMER_CYC))
    i_srs_chk (.clock(clock), .nrst(nrst), .rail_above_lockout(rail_above_lockout),
    .onoff_above_threshold(onoff_above_threshold), .over_temp(over_temp),
    .overcurrent_trip(overcurrent_trip), .sequence_select(sequence_select),
    .regulator_delay_pin_trip(regulator_delay_pin_trip), .undervoltage(undervoltage),
    .supervisor_monitor_input(supervisor_monitor_input),
    .internal_supply_rail_on(internal_supply_rail_on), .gate_drive_enable(gate_drive_enable),
    .converter_enable(converter_enable), .regulator_enable(regulator_enable),
    .ramp_done(ramp_done), .ramp_level(ramp_level), .sequence_enable(sequence_enable),
    .delay_charge_on(delay_charge_on), .delay_discharge_on(delay_discharge_on),
    .supervisor_reset_oe(supervisor_reset_oe));

/* tb/srs_stage_model.sv */
module srs_stage_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic delay_charge_on,
    input wire logic [5:0] regulator_enable,
    input wire logic [5:0] uv_force,
    output logic [3:0] regulator_delay_pin_trip,
    output logic [5:0] undervoltage
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] charge_q;
    // Shared delay capacitor, pins cross at staggered levels
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            charge_q <= 8'h00;
        end else if (!delay_charge_on) begin
            charge_q <= 8'h00;
        end else if (charge_q != 8'hFF) begin
            charge_q <= charge_q + 8'h01;
        end
    end
    assign regulator_delay_pin_trip = {charge_q >= 8'h40, charge_q >= 8'h20,
        charge_q >= 8'h10, charge_q >= 8'h03};
    // A regulator that is off sits below its good level
    assign undervoltage = ~regulator_enable | uv_force;
endmodule : srs_stage_model

/* tb/testbench.sv */
`define SRS_CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, nrst, wr_stb, rd_stb, rail, onoff, hot, oc, sel, rate, mon;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, v;
    logic [3:0] trip;
    logic [5:0] uv, uv_force, reg_en, done;
    logic [35:0] lvl;
    logic bias, rail_on, gate, conv, seq_en, chg, dis, oe, sro;
    int err_count = 0;
    int samples_checked = 0;

    srs_sequencer #(.OC_FILTER_CYC(8), .FAULT_TIMER_CYC(10)) i_srs_sequencer (
        .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata_q(rdata), .rail_above_lockout(rail),
        .onoff_above_threshold(onoff), .over_temp(hot), .overcurrent_trip(oc),
        .sequence_select(sel), .switching_rate_select(rate), .regulator_delay_pin_trip(trip),
        .undervoltage(uv), .supervisor_monitor_input(mon), .bias_on(bias),
        .internal_supply_rail_on(rail_on), .gate_drive_enable(gate), .converter_enable(conv),
        .regulator_enable(reg_en), .ramp_done(done), .ramp_level(lvl), .sequence_enable(seq_en),
        .delay_charge_on(chg), .delay_discharge_on(dis), .supervisor_reset_o(sro),
        .supervisor_reset_oe(oe));
    srs_stage_model i_srs_stage_model (.clock(clock), .nrst(nrst), .delay_charge_on(chg),
        .regulator_enable(reg_en), .uv_force(uv_force), .regulator_delay_pin_trip(trip),
        .undervoltage(uv));

    always #4 clock = ~clock;

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    task automatic ramp_wait(input int exp, input int step);
        int n;
        n = 0;
        while (done[0] !== 1'b1 && n < 3000) begin
            cyc(1);
            n++;
            if (n == step * 16 + step / 2) `SRS_CHK("mid_level", 6'h10, lvl[5:0])
        end
        `SRS_CHK("ramp_len", exp, n)
    endtask : ramp_wait

    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        $display("ERROR watchdog expected end seen hang");
        stop_test();
    end

    initial begin
        {clock, nrst, wr_stb, rd_stb, rail, onoff, hot, oc, rate} = '0;
        {sel, mon, addr, wdata, uv_force} = {2'h3, 46'h0};
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        rd(8'h04, v); `SRS_CHK("timeout_rst", 32'h0000C350, v)
        wr(8'h04, 32'h00000005);
        wr(8'h00, 32'hFFFFFFFF);
        rd(8'h04, v); `SRS_CHK("timeout", 32'h00000005, v)
        rd(8'h0C, v); `SRS_CHK("unmapped", 32'h00000000, v)
        rd(8'h00, v); `SRS_CHK("status", 3'h0, v[2:0])
        `SRS_CHK("gate", 1'b0, gate)
        `SRS_CHK("oe", 1'b1, oe)
        `SRS_CHK("reset_o", 1'b0, sro)
        $display("test registers done");
        @(posedge clock);
        {rail, onoff} <= 2'h3;
        #1 `SRS_CHK("seq_en", 1'b1, seq_en)
        `SRS_CHK("charge", 1'b1, chg)
        ramp_wait(1024, 32);
        `SRS_CHK("logic_en", 1'b1, reg_en[1])
        cyc(1100);
        `SRS_CHK("reg_en", 6'h3F, reg_en)
        `SRS_CHK("neg_end", 6'h00, lvl[35:30])
        `SRS_CHK("oe", 1'b0, oe)
        @(posedge clock);
        mon <= 1'b0;
        cyc(1);
        `SRS_CHK("oe", 1'b1, oe)
        `SRS_CHK("conv", 1'b1, conv)
        @(posedge clock);
        mon <= 1'b1;
        cyc(4); `SRS_CHK("oe", 1'b1, oe)
        cyc(4); `SRS_CHK("oe", 1'b0, oe)
        $display("test startup done");
        @(posedge clock);
        uv_force <= 6'h02;
        cyc(7); `SRS_CHK("conv", 1'b1, conv)
        @(posedge clock);
        uv_force <= 6'h00;
        @(posedge clock);
        uv_force <= 6'h02;
        cyc(7); `SRS_CHK("conv", 1'b1, conv)
        cyc(5); `SRS_CHK("conv", 1'b0, conv)
        `SRS_CHK("rail_on", 1'b1, rail_on)
        rd(8'h00, v); `SRS_CHK("fault", 1'b1, v[0])
        @(posedge clock);
        {uv_force, sel} <= 7'h00;
        #1 `SRS_CHK("discharge", 1'b1, dis)
        @(posedge clock);
        sel <= 1'b1;
        cyc(2); `SRS_CHK("conv", 1'b1, conv)
        `SRS_CHK("logic_en", 1'b0, reg_en[1])
        @(posedge clock);
        oc <= 1'b1;
        cyc(3);
        @(posedge clock);
        oc <= 1'b0;
        cyc(2); `SRS_CHK("conv", 1'b1, conv)
        @(posedge clock);
        oc <= 1'b1;
        cyc(12); `SRS_CHK("conv", 1'b0, conv)
        `SRS_CHK("rail_on", 1'b1, rail_on)
        @(posedge clock);
        {oc, onoff} <= 2'h0;
        @(posedge clock);
        onoff <= 1'b1;
        cyc(2); `SRS_CHK("conv", 1'b1, conv)
        $display("test faults done");
        @(posedge clock);
        hot <= 1'b1;
        cyc(2); `SRS_CHK("rail_on", 1'b0, rail_on)
        `SRS_CHK("conv", 1'b0, conv)
        @(posedge clock);
        {hot, onoff} <= 2'h0;
        @(posedge clock);
        onoff <= 1'b1;
        cyc(3); `SRS_CHK("conv", 1'b0, conv)
        @(posedge clock);
        rail <= 1'b0;
        cyc(1); `SRS_CHK("gate_bias", 2'h0, {gate, bias})
        @(posedge clock);
        {rail, rate} <= 2'h3;
        cyc(1);
        ramp_wait(2048, 64);
        `SRS_CHK("rail_on", 1'b1, rail_on)
        $display("test thermal done");
        stop_test();
    end
endmodule : testbench

/* verilog/srs_defines.svh */
`ifndef SRS_DEFINES_SVH
`define SRS_DEFINES_SVH

// Clock rate and timing
`define SRS_CLK_MHZ 125
`define SRS_OC_FILTER_NS 50000
`define SRS_OC_FILTER_CYC ((`SRS_OC_FILTER_NS * `SRS_CLK_MHZ + 999) / 1000)
`define SRS_FAULT_TIMER_CYC 4000
`define SRS_STEPS 32
`define SRS_STEP_CYC_LO 32
`define SRS_STEP_CYC_HI 64

// Register offsets
`define SRS_OFS_STATUS 8'h00
`define SRS_OFS_RST_TIMEOUT 8'h04

// Reset values
`define SRS_RST_TIMEOUT_RST 20'h0C350

// Status fields
`define SRS_ST_FAULT 0
`define SRS_ST_THERMAL 1
`define SRS_ST_CONV_EN 2
`define SRS_ST_REG_EN_LSB 3
`define SRS_ST_DONE_LSB 9
`define SRS_ST_SUP_LOW 15
`define SRS_ST_SEQ_ACTIVE 16
`define SRS_ST_STATE_LSB 17

`endif

/* verilog/srs_persist.sv */
module srs_persist #(
    parameter int W = 20
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic cond,
    input wire logic [W-1:0] limit,
    output logic hit
);

    logic [W-1:0] cnt_q;

    assign hit = cond && (cnt_q == limit);

    // Restarts whenever the condition drops
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else if (!cond) begin
            cnt_q <= '0;
        end else if (cnt_q != limit) begin
            cnt_q <= cnt_q + W'(1);
        end
    end

endmodule : srs_persist

/* verilog/srs_pkg.sv */
package srs_pkg;

    typedef enum logic [2:0] {
        SRS_OFF,
        SRS_CONV_RAMP,
        SRS_RUN,
        SRS_FAULTED,
        SRS_HOT
    } srs_state_e;

    typedef logic [5:0] srs_level_t;

endpackage : srs_pkg

/* verilog/srs_sequencer.sv */
// Operation
// - Under lockout: bias off, gate drives low
// - Lockout release clears fault and thermal latches
// - Enable needs rail, on/off, no latches
// - Logic rail starts after converter ramp
// - Sequence block for regulators two-five enables with converter
// - Select high and enabled: charge delay pins
// - Delay pin trip enables its regulator
// - Otherwise discharge all delay pins
// - Fresh soft-start on every enable
// - Positive references rise in 32 steps
// - Negative reference falls in 32 steps
// - Ramp lasts 1024 or 2048 cycles
// - Supervisor low on any bad condition
// - Release after monitor good for timeout
// - Supervisor output affects nothing else
// - Persistent undervoltage sets fault, regulators off
// - Fault clears on power or rising edges
// - Over-temperature latches, kills everything but bias, including rail
// - Filtered overcurrent sets fault latch
// - Overcurrent fault keeps rail, clears likewise
// - On/off rising edge clears non-thermal faults
// - Rate select picks frequency and ramp; only the ramp step (32 or 64 cycles) is implemented
//
// The placing of the registers and strobed register access are this design's own decisions.
`include "srs_defines.svh"

module srs_sequencer #(
    parameter int OC_FILTER_CYC = `SRS_OC_FILTER_CYC,
    parameter int FAULT_TIMER_CYC = `SRS_FAULT_TIMER_CYC
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata_q,
    input wire logic rail_above_lockout,
    input wire logic onoff_above_threshold,
    input wire logic over_temp,
    input wire logic overcurrent_trip,
    input wire logic sequence_select,
    input wire logic switching_rate_select,
    input wire logic [3:0] regulator_delay_pin_trip,
    input wire logic [5:0] undervoltage,
    input wire logic supervisor_monitor_input,
    output logic bias_on,
    output logic internal_supply_rail_on,
    output logic gate_drive_enable,
    output logic converter_enable,
    output logic [5:0] regulator_enable,
    output logic [5:0] ramp_done,
    output logic [35:0] ramp_level,
    output logic sequence_enable,
    output logic delay_charge_on,
    output logic delay_discharge_on,
    output logic supervisor_reset_o,
    output logic supervisor_reset_oe
);

    srs_pkg::srs_state_e state_q;
    srs_pkg::srs_state_e state_d;
    logic fault_q;
    logic thermal_q;
    logic rail_q;
    logic seq_sel_q;
    logic onoff_q;
    logic [3:0] trip_q;
    logic [19:0] rst_timeout_q;
    logic sup_low_q;

    logic rail_rise;
    logic seq_rise;
    logic onoff_rise;
    logic enabled;
    logic seq_active;
    logic [3:0] trip_d;
    logic uv_cond;
    logic uv_hit;
    logic oc_hit;
    logic fault_set;
    logic fault_clr;
    logic fault_d;
    logic thermal_set;
    logic thermal_d;
    logic sup_bad;
    logic sup_good_hit;
    logic sel_status;
    logic sel_timeout;
    logic [31:0] status_word;
    logic [31:0] rdata_d;
    logic [19:0] timeout_d;

    // Edge detection for clear events
    assign rail_rise = rail_above_lockout && !rail_q;
    assign seq_rise = sequence_select && !seq_sel_q;
    assign onoff_rise = onoff_above_threshold && !onoff_q;

    assign enabled = rail_above_lockout && onoff_above_threshold && !fault_q && !thermal_q;

    assign bias_on = rail_above_lockout;
    assign gate_drive_enable = rail_above_lockout && enabled;

    assign internal_supply_rail_on = !thermal_q;

    assign converter_enable = enabled;
    assign sequence_enable = enabled;
    assign seq_active = enabled && sequence_select;

    assign delay_charge_on = seq_active;
    assign delay_discharge_on = !seq_active;

    assign trip_d = enabled ? (trip_q | (regulator_delay_pin_trip & {4{seq_active}})) : 4'h0;

    assign regulator_enable[0] = enabled;
    assign regulator_enable[1] = enabled && ramp_done[0];
    assign regulator_enable[5:2] = trip_q & {4{enabled}};

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_ramp
            srs_softstart #(
                .NEGATIVE(gi == 5)
            ) u_ramp (
                .clock(clock),
                .nrst(nrst),
                .enable(regulator_enable[gi]),
                .rate_hi(switching_rate_select),
                .level_q(ramp_level[gi*6 +: 6]),
                .done(ramp_done[gi])
            );
        end
    endgenerate
    // Negative ramp is the last instance

    assign uv_cond = |(undervoltage & ramp_done & regulator_enable);

    srs_persist #(
        .W(32)
    ) u_uv_timer (
        .clock(clock),
        .nrst(nrst),
        .cond(uv_cond),
        .limit(32'(FAULT_TIMER_CYC - 1)),
        .hit(uv_hit)
    );

    srs_persist #(
        .W(32)
    ) u_oc_filter (
        .clock(clock),
        .nrst(nrst),
        .cond(overcurrent_trip),
        .limit(32'(OC_FILTER_CYC - 1)),
        .hit(oc_hit)
    );

    assign fault_set = uv_hit || oc_hit;

    // Clear on power cycle or edges
    assign fault_clr = rail_rise || ((seq_rise || onoff_rise) && !overcurrent_trip);
    assign fault_d = fault_set ? 1'b1 : (fault_clr ? 1'b0 : fault_q);

    assign thermal_set = over_temp;
    assign thermal_d = thermal_set ? 1'b1 : (rail_rise ? 1'b0 : thermal_q);

    assign sup_bad = !supervisor_monitor_input || !rail_above_lockout ||
                     !onoff_above_threshold || fault_q || thermal_q;

    srs_persist #(
        .W(20)
    ) u_sup_timer (
        .clock(clock),
        .nrst(nrst),
        .cond(!sup_bad),
        .limit(rst_timeout_q),
        .hit(sup_good_hit)
    );

    assign supervisor_reset_o = 1'b0;
    assign supervisor_reset_oe = sup_low_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            srs_pkg::SRS_OFF: begin
                if (enabled) begin
                    state_d = srs_pkg::SRS_CONV_RAMP;
                end
            end
            srs_pkg::SRS_CONV_RAMP: begin
                if (ramp_done[0]) begin
                    state_d = srs_pkg::SRS_RUN;
                end
            end
            srs_pkg::SRS_RUN: begin
                state_d = srs_pkg::SRS_RUN;
            end
            srs_pkg::SRS_FAULTED: begin
                state_d = srs_pkg::SRS_FAULTED;
            end
            srs_pkg::SRS_HOT: begin
                state_d = srs_pkg::SRS_HOT;
            end
            default: begin
                state_d = srs_pkg::SRS_OFF;
            end
        endcase
        if (thermal_d) begin
            state_d = srs_pkg::SRS_HOT;
        end else if (fault_d) begin
            state_d = srs_pkg::SRS_FAULTED;
        end else if (!(rail_above_lockout && onoff_above_threshold)) begin
            state_d = srs_pkg::SRS_OFF;
        end else if (state_q == srs_pkg::SRS_FAULTED || state_q == srs_pkg::SRS_HOT) begin
            state_d = srs_pkg::SRS_OFF;
        end
    end

    // Register decode
    assign sel_status = (addr == `SRS_OFS_STATUS);
    assign sel_timeout = (addr == `SRS_OFS_RST_TIMEOUT);
    assign timeout_d = (wr_stb && sel_timeout) ? wdata[19:0] : rst_timeout_q;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`SRS_ST_FAULT] = fault_q;
        status_word[`SRS_ST_THERMAL] = thermal_q;
        status_word[`SRS_ST_CONV_EN] = converter_enable;
        status_word[`SRS_ST_REG_EN_LSB +: 6] = regulator_enable;
        status_word[`SRS_ST_DONE_LSB +: 6] = ramp_done;
        status_word[`SRS_ST_SUP_LOW] = sup_low_q;
        status_word[`SRS_ST_SEQ_ACTIVE] = seq_active;
        status_word[`SRS_ST_STATE_LSB +: 3] = state_q;
    end

    assign rdata_d = !rd_stb ? 32'h0000_0000 :
                     sel_status ? status_word :
                     sel_timeout ? {12'h000, rst_timeout_q} : 32'h0000_0000;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_timeout_q <= `SRS_RST_TIMEOUT_RST;
        end else begin
            rst_timeout_q <= timeout_d;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rail_q <= 1'b0;
            seq_sel_q <= 1'b0;
            onoff_q <= 1'b0;
        end else begin
            rail_q <= rail_above_lockout;
            seq_sel_q <= sequence_select;
            onoff_q <= onoff_above_threshold;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault_d;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            thermal_q <= 1'b0;
        end else begin
            thermal_q <= thermal_d;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            trip_q <= 4'h0;
        end else begin
            trip_q <= trip_d;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= srs_pkg::SRS_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // Supervisor holds low until timeout
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sup_low_q <= 1'b1;
        end else if (sup_bad) begin
            sup_low_q <= 1'b1;
        end else if (sup_good_hit) begin
            sup_low_q <= 1'b0;
        end
    end

endmodule : srs_sequencer

/* verilog/srs_softstart.sv */
`include "srs_defines.svh"

module srs_softstart #(
    parameter bit NEGATIVE = 1'b0
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic enable,
    input wire logic rate_hi,
    output srs_pkg::srs_level_t level_q,
    output logic done
);

    logic [5:0] cyc_q;
    logic [5:0] step_q;
    logic [5:0] step_d;
    logic [5:0] cyc_d;
    logic [5:0] last_cyc;
    logic at_end;

    assign last_cyc = rate_hi ? 6'(`SRS_STEP_CYC_HI - 1) : 6'(`SRS_STEP_CYC_LO - 1);
    assign at_end = (step_q == 6'(`SRS_STEPS));
    assign done = at_end;

    always_comb begin
        step_d = step_q;
        cyc_d = cyc_q;
        if (!enable) begin
            step_d = 6'h00;
            cyc_d = 6'h00;
        end else if (!at_end) begin
            if (cyc_q == last_cyc) begin
                cyc_d = 6'h00;
                step_d = step_q + 6'h01;
            end else begin
                cyc_d = cyc_q + 6'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cyc_q <= 6'h00;
            step_q <= 6'h00;
            level_q <= NEGATIVE ? 6'(`SRS_STEPS) : 6'h00;
        end else begin
            cyc_q <= cyc_d;
            step_q <= step_d;
            level_q <= NEGATIVE ? (6'(`SRS_STEPS) - step_d) : step_d;
        end
    end

endmodule : srs_softstart
